//--- tps_regs_cfg.svh
// Purpose: Offsets, field positions and reset values of the test pattern and serializer registers.
// Assumes: Byte-wide registers on the device's own control port.
// Notes: Definitions only.
`ifndef TPS_REGS_CFG_SVH
`define TPS_REGS_CFG_SVH

`define TPS_ADDR_W 10
`define TPS_OFS_SER_ADJ 10'h015
`define TPS_OFS_PAT1_LO 10'h019
`define TPS_OFS_PAT1_HI 10'h01A
`define TPS_OFS_PAT2_LO 10'h01B
`define TPS_OFS_PAT2_HI 10'h01C
`define TPS_OFS_PAT3_LO 10'h01D
`define TPS_OFS_PAT3_HI 10'h01E
`define TPS_OFS_PAT4_LO 10'h01F
`define TPS_OFS_PAT4_HI 10'h020
`define TPS_OFS_SYNTH 10'h021

`define TPS_RST_SER_ADJ 8'h54
`define TPS_RST_PAT 8'h00
`define TPS_RST_SYNTH 8'h00

`define TPS_POL_BIT 7
`define TPS_EMPH_HI 6
`define TPS_EMPH_LO 5
`define TPS_REG_PD_BIT 4
`define TPS_SYNTH_RSV_BIT 3
`define TPS_SYNTH_MASK 8'h18

`define TPS_GEN_USER 4'h8
`define TPS_LINK_TST_MIN 4'h4
`define TPS_LINK_TST_MAX 4'h7

`endif

//--- tps_pkg.sv
// Purpose: Types shared by the register bank and its pattern sequencer.
// Assumes: Constants live in tps_regs_cfg.svh.
// Notes: One-hot sequencer states.
package tps_pkg;
    typedef enum logic [5:0] {
        SEQ_IDLE = 6'h01,
        SEQ_P1 = 6'h02,
        SEQ_P2 = 6'h04,
        SEQ_P3 = 6'h08,
        SEQ_P4 = 6'h10,
        SEQ_ZERO = 6'h20
    } seq_state_e;
    typedef logic [15:0] pat_word_t;
endpackage : tps_pkg

//--- user_pattern_seq.sv
// Purpose: Steps through the four user pattern words once per sample enable.
// Assumes: Inputs come from logic on clk_i; sample_en_i is a one-cycle pulse.
// Notes: Single mode stops on zeros until user mode is left.
`timescale 1ns/1ps
`default_nettype none
module user_pattern_seq #(
    parameter int WORD_W = 16
) (
    input wire logic clk_i,                   // Core clock.
    input wire logic rst_b_i,                 // Asynchronous reset, active low.
    input wire logic user_mode_i,             // Generator is in user mode.
    input wire logic single_i,                // One pass of the four words, then zeros.
    input wire logic sample_en_i,             // One-cycle sample clock enable.
    input wire logic [4*WORD_W-1:0] words_i,  // Words 4..1, word 1 in the low bits.
    output logic [WORD_W-1:0] data_o,         // Current test word.
    output logic active_o                     // Sequencer is driving a pattern word.
);
    tps_pkg::seq_state_e state_q, state_d;
    logic [WORD_W-1:0] data_q, data_d;

    always_comb begin
        state_d = state_q;
        data_d = data_q;
        if (!user_mode_i) begin
            state_d = tps_pkg::SEQ_IDLE;
            data_d = '0;
        end else if (sample_en_i) begin
            case (state_q)
                tps_pkg::SEQ_IDLE: state_d = tps_pkg::SEQ_P1;
                tps_pkg::SEQ_P1: state_d = tps_pkg::SEQ_P2;
                tps_pkg::SEQ_P2: state_d = tps_pkg::SEQ_P3;
                tps_pkg::SEQ_P3: state_d = tps_pkg::SEQ_P4;
                tps_pkg::SEQ_P4: state_d = single_i ? tps_pkg::SEQ_ZERO : tps_pkg::SEQ_P1;
                tps_pkg::SEQ_ZERO: state_d = tps_pkg::SEQ_ZERO;
                default: state_d = tps_pkg::SEQ_IDLE;
            endcase
            case (state_d)
                tps_pkg::SEQ_P1: data_d = words_i[WORD_W-1:0];
                tps_pkg::SEQ_P2: data_d = words_i[2*WORD_W-1:WORD_W];
                tps_pkg::SEQ_P3: data_d = words_i[3*WORD_W-1:2*WORD_W];
                tps_pkg::SEQ_P4: data_d = words_i[4*WORD_W-1:3*WORD_W];
                default: data_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= tps_pkg::SEQ_IDLE;
            data_q <= '0;
        end else begin
            state_q <= state_d;
            data_q <= data_d;
        end
    end

    assign data_o = data_q;
    assign active_o = (state_q != tps_pkg::SEQ_IDLE) && (state_q != tps_pkg::SEQ_ZERO);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_fourth_single;
        state_q == tps_pkg::SEQ_P4 && user_mode_i && single_i && sample_en_i;
    endsequence

    a_single_ends_zero: assert property (s_fourth_single |=> state_q == tps_pkg::SEQ_ZERO
        && data_q == '0)
        else $error("single pass did not end on zeros");
    a_first_word_out: assert property (state_q == tps_pkg::SEQ_IDLE && user_mode_i && sample_en_i
        |=> data_q == $past(words_i[WORD_W-1:0]))
        else $error("first pattern word not shown");
    a_off_mode_idle: assert property (!user_mode_i |=> state_q == tps_pkg::SEQ_IDLE
        && data_q == '0)
        else $error("sequencer ran outside user mode");
endmodule : user_pattern_seq
`default_nettype wire

//--- test_pattern_serializer_regs.sv
// Purpose: Serializer adjust, user test pattern and synthesizer control registers.
// Assumes: The control port logic runs on clk_i and presents byte writes and reads.
// Notes: Mode fields of other registers arrive as inputs from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "tps_regs_cfg.svh"
module test_pattern_serializer_regs #(
    parameter int ADDR_W = `TPS_ADDR_W
) (
    input wire logic clk_i,                   // Core clock, 250 MHz.
    input wire logic rst_b_i,                 // Asynchronous reset, active low.
    input wire logic [ADDR_W-1:0] reg_addr_i, // Register address.
    input wire logic reg_wr_i,                // Write strobe, one cycle.
    input wire logic reg_rd_i,                // Read strobe, one cycle.
    input wire logic [7:0] reg_wdata_i,       // Write data.
    output logic [7:0] reg_rdata_o,           // Read data, valid the cycle after reg_rd_i.
    input wire logic [3:0] gen_mode_i,        // Test generator mode field.
    input wire logic single_i,                // Single-pattern bit.
    input wire logic [3:0] link_test_i,       // Link layer test mode field.
    input wire logic sample_en_i,             // Sample clock enable pulse.
    output logic ser_invert_o,                // Serializer polarity inverted.
    output logic [1:0] emph_code_o,           // De-emphasis amplitude code.
    output logic linear_regulator_pd_o,       // Force synth_oscillator regulator power-down.
    output logic [7:0] link_pat_lo_o,         // Pattern 1 low byte in user mode or link tests, else zero.
    output logic [15:0] test_data_o,          // User pattern word from the sequencer.
    output logic test_active_o                // Sequencer shows a pattern word.
);
    localparam int NREG = 10;
    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];
    logic [7:0] rdata_q, rdata_d;
    logic user_mode, link_mode;
    tps_pkg::pat_word_t word [4];
    logic [63:0] words_gated;

    function automatic logic [ADDR_W-1:0] reg_ofs(input int idx);
        case (idx)
            0: reg_ofs = ADDR_W'(`TPS_OFS_SER_ADJ);
            1: reg_ofs = ADDR_W'(`TPS_OFS_PAT1_LO);
            2: reg_ofs = ADDR_W'(`TPS_OFS_PAT1_HI);
            3: reg_ofs = ADDR_W'(`TPS_OFS_PAT2_LO);
            4: reg_ofs = ADDR_W'(`TPS_OFS_PAT2_HI);
            5: reg_ofs = ADDR_W'(`TPS_OFS_PAT3_LO);
            6: reg_ofs = ADDR_W'(`TPS_OFS_PAT3_HI);
            7: reg_ofs = ADDR_W'(`TPS_OFS_PAT4_LO);
            8: reg_ofs = ADDR_W'(`TPS_OFS_PAT4_HI);
            default: reg_ofs = ADDR_W'(`TPS_OFS_SYNTH);
        endcase
    endfunction : reg_ofs

    // Reset contents by register index.
    function automatic logic [7:0] reg_rst(input int idx);
        if (idx == 0) begin
            reg_rst = `TPS_RST_SER_ADJ;
        end else if (idx == NREG - 1) begin
            reg_rst = `TPS_RST_SYNTH;
        end else begin
            reg_rst = `TPS_RST_PAT;
        end
    endfunction : reg_rst

    // Unused synthesizer bits are masked on write, so they always read back as zero.
    function automatic logic [7:0] reg_mask(input int idx);
        reg_mask = (idx == NREG - 1) ? `TPS_SYNTH_MASK : 8'hFF;
    endfunction : reg_mask

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = 1'b0;
        for (int i = 0; i < NREG; i++) begin
            if (a == reg_ofs(i)) begin
                addr_mapped = 1'b1;
            end
        end
    endfunction : addr_mapped

    // A read in the same cycle as a write to that register returns the old contents.
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            rdata_d = 8'h00;
        end
        for (int i = 0; i < NREG; i++) begin
            regs_d[i] = regs_q[i];
            if (reg_wr_i && reg_addr_i == reg_ofs(i)) begin
                regs_d[i] = reg_wdata_i & reg_mask(i);
            end
            if (reg_rd_i && reg_addr_i == reg_ofs(i)) begin
                rdata_d = regs_q[i];
            end
        end
    end

    generate
        for (genvar g = 0; g < NREG; g++) begin : g_reg
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    regs_q[g] <= reg_rst(g);
                end else begin
                    regs_q[g] <= regs_d[g];
                end
            end
        end
        // Words are built live from the byte registers, so each byte may change on its own.
        for (genvar w = 0; w < 4; w++) begin : g_word
            assign word[w] = {regs_q[2*w+2], regs_q[2*w+1]};
            assign words_gated[16*w+15:16*w] = user_mode ? word[w] : 16'h0000;
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign user_mode = (gen_mode_i == `TPS_GEN_USER);
    assign link_mode = (link_test_i >= `TPS_LINK_TST_MIN) && (link_test_i <= `TPS_LINK_TST_MAX);
    assign ser_invert_o = regs_q[0][`TPS_POL_BIT];
    assign emph_code_o = regs_q[0][`TPS_EMPH_HI:`TPS_EMPH_LO];
    assign linear_regulator_pd_o = regs_q[NREG-1][`TPS_REG_PD_BIT];
    // The link layer reuses the pattern 1 low byte, so that byte has its own gate.
    assign link_pat_lo_o = (user_mode || link_mode) ? regs_q[1] : 8'h00;

    // All four words reach the sequencer only in user mode.
    user_pattern_seq #(
        .WORD_W(16)
    ) u_seq (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .user_mode_i(user_mode),
        .single_i(single_i),
        .sample_en_i(sample_en_i),
        .words_i(words_gated),
        .data_o(test_data_o),
        .active_o(test_active_o)
    );

    // Checks on the register bank; the sequencer carries its own.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_pol_follows_write: assert property (reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_SER_ADJ)
        |=> ser_invert_o == $past(reg_wdata_i[7]))
        else $error("polarity does not follow write");
    a_emph_follows_write: assert property (reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_SER_ADJ)
        |=> emph_code_o == $past(reg_wdata_i[6:5]))
        else $error("emphasis code does not follow write");
    a_adj_reset_value: assert property ($rose(rst_b_i) |-> regs_q[0] == 8'h54)
        else $error("serializer adjust reset value wrong");
    a_link_lo_gate: assert property (!user_mode && !link_mode
        |-> link_pat_lo_o == 8'h00)
        else $error("pattern 1 low byte leaks outside its modes");
    a_link_lo_pass: assert property (link_mode |-> link_pat_lo_o == regs_q[1])
        else $error("pattern 1 low byte missing in link test");
    a_pat_readback: assert property (reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_PAT3_HI)
        ##1 reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_PAT3_HI)
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("pattern byte readback mismatch");
    a_words_gated: assert property (!user_mode
        |-> words_gated == 64'h0)
        else $error("pattern words used outside user mode");
    a_word_order: assert property (user_mode
        |-> words_gated[63:48] == {regs_q[8], regs_q[7]})
        else $error("pattern 4 byte order wrong");
    a_pd_follows: assert property (reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_SYNTH)
        |=> linear_regulator_pd_o == $past(reg_wdata_i[4]) && regs_q[9][7:5] == 3'h0)
        else $error("regulator power-down not set by write");

    sequence s_adj_write;
        reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_SER_ADJ);
    endsequence

    sequence s_synth_write;
        reg_wr_i && reg_addr_i == ADDR_W'(`TPS_OFS_SYNTH);
    endsequence

    // The reserved adjust bits are plain storage, so software can write back what it read.
    a_adj_stores_all: assert property (s_adj_write
        |=> regs_q[0] == $past(reg_wdata_i))
        else $error("serializer adjust byte not stored");
    a_pol_holds: assert property (!reg_wr_i |=> $stable(ser_invert_o))
        else $error("polarity changed without a write");
    a_emph_holds: assert property (!reg_wr_i |=> $stable(emph_code_o))
        else $error("emphasis code changed without a write");
    a_synth_stores: assert property (s_synth_write
        |=> regs_q[NREG-1] == ($past(reg_wdata_i) & `TPS_SYNTH_MASK))
        else $error("synthesizer control byte not stored");
    a_synth_unused: assert property ((regs_q[NREG-1] & ~`TPS_SYNTH_MASK) == 8'h00)
        else $error("unused synthesizer bits set");
    a_pd_holds: assert property (!reg_wr_i |=> $stable(linear_regulator_pd_o))
        else $error("regulator power-down changed without a write");
    a_pat_lo_stores: assert property (reg_wr_i
        && reg_addr_i == ADDR_W'(`TPS_OFS_PAT1_LO) |=> regs_q[1] == $past(reg_wdata_i))
        else $error("pattern 1 low byte not stored");

    a_read_stands: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (reg_rd_i && !addr_mapped(reg_addr_i)
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_link_lo_user: assert property (user_mode |-> link_pat_lo_o == regs_q[1])
        else $error("pattern 1 low byte missing in user mode");
    a_pat1_hi_used: assert property (user_mode |-> words_gated[15:8] == regs_q[2])
        else $error("pattern 1 high byte missing in user mode");
endmodule : test_pattern_serializer_regs
`default_nettype wire

//--- test_pattern_serializer_regs_tb.sv
// Purpose: Self-checking bench for the test pattern and serializer register bank.
// Assumes: Strobe register port and sequencer contract as handed over; inputs driven on negedge.
// Notes: Expected values come from the register offsets and reset values in the config header.
`timescale 1ns/1ps
`default_nettype none
`include "tps_regs_cfg.svh"
module test_pattern_serializer_regs_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] reg_addr_i = 10'h000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [3:0] gen_mode_i = 4'h0;
    logic single_i = 1'b0;
    logic [3:0] link_test_i = 4'h0;
    logic sample_en_i = 1'b0;
    logic ser_invert_o;
    logic [1:0] emph_code_o;
    logic linear_regulator_pd_o;
    logic [7:0] link_pat_lo_o;
    logic [15:0] test_data_o;
    logic test_active_o;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [9:0] pat_ofs [8] = '{`TPS_OFS_PAT1_LO, `TPS_OFS_PAT1_HI, `TPS_OFS_PAT2_LO,
        `TPS_OFS_PAT2_HI, `TPS_OFS_PAT3_LO, `TPS_OFS_PAT3_HI, `TPS_OFS_PAT4_LO, `TPS_OFS_PAT4_HI};

    test_pattern_serializer_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .gen_mode_i(gen_mode_i), .single_i(single_i),
        .link_test_i(link_test_i), .sample_en_i(sample_en_i), .ser_invert_o(ser_invert_o),
        .emph_code_o(emph_code_o), .linear_regulator_pd_o(linear_regulator_pd_o),
        .link_pat_lo_o(link_pat_lo_o), .test_data_o(test_data_o), .test_active_o(test_active_o));

    always #2 clk_i = ~clk_i;

    function automatic logic [7:0] pat_byte(input int k);
        return 8'h3C + 8'(k * 17);
    endfunction : pat_byte

    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // The limit sits far above the roughly 400 cycles the scenarios need.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : reg_write

    task automatic reg_expect(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        check("read data", {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : reg_expect

    task automatic test_reset_values();
        check("polarity", {15'h0, ser_invert_o}, 16'h0000);
        check("emphasis", {14'h0, emph_code_o}, 16'h0002);
        check("regulator", {15'h0, linear_regulator_pd_o}, 16'h0000);
        reg_expect(`TPS_OFS_SER_ADJ, `TPS_RST_SER_ADJ);
        reg_expect(`TPS_OFS_SYNTH, `TPS_RST_SYNTH);
        for (int k = 0; k < 8; k++) reg_expect(pat_ofs[k], `TPS_RST_PAT);
    endtask : test_reset_values

    task automatic test_serializer();
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            v = {c[2], c[1:0], 5'h14};
            reg_write(`TPS_OFS_SER_ADJ, v);
            check("polarity", {15'h0, ser_invert_o}, {15'h0, v[7]});
            check("emphasis", {14'h0, emph_code_o}, {14'h0, v[6:5]});
            reg_expect(`TPS_OFS_SER_ADJ, v);
        end
    endtask : test_serializer

    task automatic test_synth();
        reg_write(`TPS_OFS_SYNTH, 8'hFF);
        check("regulator", {15'h0, linear_regulator_pd_o}, 16'h0001);
        reg_expect(`TPS_OFS_SYNTH, `TPS_SYNTH_MASK);
        reg_write(`TPS_OFS_SYNTH, 8'h08);
        check("regulator", {15'h0, linear_regulator_pd_o}, 16'h0000);
        reg_write(10'h3FF, 8'hA5);
        reg_expect(10'h3FF, 8'h00);
    endtask : test_synth

    task automatic test_pattern_bytes();
        for (int k = 0; k < 8; k++) reg_write(pat_ofs[k], pat_byte(k));
        for (int k = 0; k < 8; k++) reg_expect(pat_ofs[k], pat_byte(k));
    endtask : test_pattern_bytes

    task automatic test_link_byte();
        logic used;
        logic [7:0] want;
        for (int m = 0; m < 256; m++) begin
            @(negedge clk_i);
            gen_mode_i = m[7:4];
            link_test_i = m[3:0];
            used = (m[7:4] == 4'h8) || (m[3:0] >= 4'h4 && m[3:0] <= 4'h7);
            want = used ? pat_byte(0) : 8'h00;
            #1 check("link byte", {8'h00, link_pat_lo_o}, {8'h00, want});
        end
        @(negedge clk_i);
        gen_mode_i = 4'h0;
        link_test_i = 4'h0;
    endtask : test_link_byte

    task automatic step_expect(input logic [15:0] exp, input logic act);
        @(negedge clk_i);
        check("test word", test_data_o, exp);
        check("active", {15'h0, test_active_o}, {15'h0, act});
    endtask : step_expect

    task automatic test_sequencer();
        @(negedge clk_i);
        gen_mode_i = 4'h4;
        sample_en_i = 1'b1;
        step_expect(16'h0000, 1'b0);
        gen_mode_i = `TPS_GEN_USER;
        single_i = 1'b1;
        for (int n = 0; n < 4; n++)
            step_expect({pat_byte(2 * n + 1), pat_byte(2 * n)}, 1'b1);
        step_expect(16'h0000, 1'b0);
        step_expect(16'h0000, 1'b0);
        gen_mode_i = 4'h0;
        step_expect(16'h0000, 1'b0);
        gen_mode_i = `TPS_GEN_USER;
        single_i = 1'b0;
        for (int n = 0; n < 6; n++)
            step_expect({pat_byte(2 * (n % 4) + 1), pat_byte(2 * (n % 4))}, 1'b1);
        sample_en_i = 1'b0;
        step_expect({pat_byte(3), pat_byte(2)}, 1'b1);
        gen_mode_i = 4'h0;
        step_expect(16'h0000, 1'b0);
    endtask : test_sequencer

    task automatic test_back_to_back();
        @(negedge clk_i);
        reg_addr_i = `TPS_OFS_PAT3_HI;
        reg_wdata_i = 8'h96;
        reg_wr_i = 1'b1;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        check("old read", {8'h00, reg_rdata_o}, {8'h00, pat_byte(5)});
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        check("read data", {8'h00, reg_rdata_o}, 16'h0096);
    endtask : test_back_to_back

    task automatic test_mid_reset();
        reg_write(`TPS_OFS_SER_ADJ, 8'hB4);
        check("polarity", {15'h0, ser_invert_o}, 16'h0001);
        reg_write(`TPS_OFS_SYNTH, 8'h10);
        reg_expect(`TPS_OFS_SYNTH, 8'h10);
        @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (10) @(negedge clk_i);
        check("polarity", {15'h0, ser_invert_o}, 16'h0000);
        check("regulator", {15'h0, linear_regulator_pd_o}, 16'h0000);
        check("read data", {8'h00, reg_rdata_o}, 16'h0000);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        check("emphasis", {14'h0, emph_code_o}, 16'h0002);
        reg_expect(`TPS_OFS_SER_ADJ, `TPS_RST_SER_ADJ);
        reg_expect(`TPS_OFS_PAT3_HI, `TPS_RST_PAT);
    endtask : test_mid_reset

    initial begin
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        test_reset_values();
        test_serializer();
        test_synth();
        test_pattern_bytes();
        test_link_byte();
        test_sequencer();
        test_back_to_back();
        test_mid_reset();
        end_of_test();
    end
endmodule : test_pattern_serializer_regs_tb
`default_nettype wire
